// ==== hw/lfm_fault_mgr.sv ====
// fault manager for a four-string led driver: alarm line, partial short, apb registers
`timescale 1ns/1ns
`default_nettype none
`include "lfm_params.svh"
module lfm_fault_mgr #(
    parameter int HOLD_CYC = `LFM_HOLD_CYC
) (
    input  wire logic                   clk_i,
    input  wire logic                   reset_i,
    input  wire logic                   psel_i,
    input  wire logic                   penable_i,
    input  wire logic                   pwrite_i,
    input  wire logic [`LFM_AW-1:0]     paddr_i,
    input  wire logic [31:0]            pwdata_i,
    output logic      [31:0]            prdata_o,
    output logic                        pready_o,
    output logic                        pslverr_o,
    input  wire logic                   enable_i,
    input  wire logic                   dim_i,
    input  wire logic                   input_undervoltage_lockout_i,
    input  wire logic                   latch_fault_i,
    input  wire logic [`LFM_NSTR-1:0]   over_partial_short_threshold_i,
    input  wire logic [`LFM_NSTR-1:0]   pin_in_regulation_i,
    input  wire logic                   alarm_i,
    output logic                        alarm_o,
    output logic                        alarm_oe_n_o,
    output logic                        boost_en_o,
    output logic                        disconnect_en_o,
    output logic [`LFM_NSTR-1:0]        sink_en_o
);
    localparam int NS      = `LFM_NSTR;
    localparam int SW      = 2 * NS + 5;
    localparam int HOLD_CW = `LFM_HOLD_CW;
    localparam int NH      = `LFM_DRV_HIST;

    logic [SW-1:0]   raw;
    logic [SW-1:0]   syn;
    logic [NS-1:0]   hi_s;
    logic [NS-1:0]   lo_s;
    logic            enable_s;
    logic            dim_s;
    logic            input_undervoltage_lockout_s;
    logic            lfault_s;
    logic            alarm_s;
    logic [NS-1:0]   str_en;
    logic [NS-1:0]   str_flag;
    logic [NS-1:0]   str_hit;
    logic [NS-1:0]   cand;
    logic            dim_rise;
    logic            hold_cond;
    logic            clear_all;
    logic            drive;
    logic            ext_low;
    logic            run_ok;
    logic            trip_all;
    logic            apb_setup;
    logic            apb_wr;
    logic [31:0]     rdata;
    logic            rerr;

    lfm_pkg::lfm_top_reg_t s_r;
    lfm_pkg::lfm_top_reg_t s_nxt;

    // every comparator and control input passes one two-flop synchroniser
    assign raw = {over_partial_short_threshold_i, pin_in_regulation_i, enable_i, dim_i,
                  input_undervoltage_lockout_i, latch_fault_i, alarm_i};

    lfm_sync #(
        .W (SW)
    ) u_sync (
        .clk_i   (clk_i),
        .reset_i (reset_i),
        .d_i     (raw),
        .q_o     (syn)
    );

    assign {hi_s, lo_s, enable_s, dim_s, input_undervoltage_lockout_s, lfault_s, alarm_s} = syn;

    assign dim_rise  = dim_s & ~s_r.dim_d;
    assign hold_cond = ~enable_s | ~dim_s;
    assign clear_all = input_undervoltage_lockout_s | s_r.hold_clr;

    lfm_str_if sif [NS] ();

    genvar g;
    for (g = 0; g < NS; g++) begin : g_str
        logic [NS-1:0] others;
        // a string in regulation elsewhere must be enabled and in use
        assign others  = lo_s & str_en & s_r.str_mask & ~(NS'(1) << g);
        assign cand[g] = hi_s[g] & s_r.str_mask[g] & (|others);

        assign sif[g].dim      = dim_s;
        assign sif[g].dim_rise = dim_rise;
        assign sif[g].cand     = cand[g];
        assign sif[g].clear    = clear_all;
        assign str_en[g]       = sif[g].en;
        assign str_flag[g]     = sif[g].flag;
        assign str_hit[g]      = sif[g].hit;

        lfm_string u_str (
            .clk_i   (clk_i),
            .reset_i (reset_i),
            .sif     (sif[g])
        );
    end

    // own alarm drive: any string flag or a latched fault pulls the line
    assign drive = s_r.latched | (|str_flag);

    // our own release reaches the synchronised line late, so mask the recent drive history
    assign ext_low = s_r.mode & ~alarm_s & ~drive & ~(|s_r.drv_hist);

    assign run_ok   = enable_s & ~input_undervoltage_lockout_s & ~s_r.latched & ~ext_low;
    assign trip_all = lfault_s | (s_r.mode & (|str_hit));

    assign apb_setup = psel_i & ~penable_i;
    assign apb_wr    = psel_i & penable_i & pwrite_i & s_r.pready;

    always_comb begin
        rdata = '0;
        rerr  = 1'b0;
        case (paddr_i)
            `LFM_CTRL_OFF: begin
                rdata[`LFM_CTRL_MODE_BIT] = s_r.mode;
                rdata[`LFM_CTRL_MASK_LSB +: NS] = s_r.str_mask;
            end
            `LFM_STAT_OFF: begin
                rdata[`LFM_STAT_FLAG_LSB +: NS] = str_flag;
                rdata[`LFM_STAT_DIS_LSB +: NS] = ~str_en;
                rdata[`LFM_STAT_LAT_BIT] = s_r.latched;
                rdata[`LFM_STAT_EXT_BIT] = ext_low;
                rdata[`LFM_STAT_DRV_BIT] = drive;
            end
            default: begin
                rerr = 1'b1;
            end
        endcase
    end

    always_comb begin
        s_nxt          = s_r;
        s_nxt.dim_d    = dim_s;
        s_nxt.hold_clr = 1'b0;
        s_nxt.drv_hist = {s_r.drv_hist[NH-2:0], drive};

        if (!hold_cond) begin
            s_nxt.hold_cnt = '0;
        end else if (s_r.hold_cnt != HOLD_CW'(HOLD_CYC)) begin
            s_nxt.hold_cnt = s_r.hold_cnt + 1'b1;
            s_nxt.hold_clr = (s_r.hold_cnt == HOLD_CW'(HOLD_CYC - 1));
        end

        // the line level plays no part here, and a new fault beats a clear
        if (clear_all) begin
            s_nxt.latched = 1'b0;
        end
        if (trip_all) begin
            s_nxt.latched = 1'b1;
        end

        s_nxt.boost  = run_ok;
        s_nxt.disc   = enable_s & ~input_undervoltage_lockout_s & ~s_r.latched;
        s_nxt.sinks  = (run_ok & dim_s) ? (str_en & s_r.str_mask) : '0;
        s_nxt.oe_n   = ~drive;
        s_nxt.al_lvl = 1'b0;

        s_nxt.pready  = apb_setup;
        s_nxt.pslverr = apb_setup & rerr;
        s_nxt.prdata  = apb_setup ? rdata : '0;

        if (apb_wr && paddr_i == `LFM_CTRL_OFF) begin
            s_nxt.mode     = pwdata_i[`LFM_CTRL_MODE_BIT];
            s_nxt.str_mask = pwdata_i[`LFM_CTRL_MASK_LSB +: NS];
        end
    end

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            s_r          <= '0;
            s_r.mode     <= `LFM_MODE_RST;
            s_r.str_mask <= `LFM_MASK_RST;
            s_r.oe_n     <= 1'b1;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign prdata_o        = s_r.prdata;
    assign pready_o        = s_r.pready;
    assign pslverr_o       = s_r.pslverr;
    assign alarm_o         = s_r.al_lvl;
    assign alarm_oe_n_o    = s_r.oe_n;
    assign boost_en_o      = s_r.boost;
    assign disconnect_en_o = s_r.disc;
    assign sink_en_o       = s_r.sinks;

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (reset_i);

    AST_ISO_IGNORES_LINE: assert property (!s_r.mode && !alarm_s && enable_s && !input_undervoltage_lockout_s && !s_r.latched
                                           |=> boost_en_o)
        else $error("line level acted on in isolate option");

    AST_DRIVE_ON_FAULT: assert property ($rose(s_r.latched) |=> !alarm_oe_n_o)
        else $error("alarm line not driven after latched fault");

    AST_EXT_SHUTDOWN: assert property (ext_low |=> !boost_en_o && sink_en_o == '0
                                       && disconnect_en_o == $past(enable_s && !input_undervoltage_lockout_s && !s_r.latched))
        else $error("external low did not stop boost and sinks");

    AST_EXT_KEEPS_FLAG: assert property (ext_low && !trip_all && !clear_all
                                         |=> s_r.latched == $past(s_r.latched))
        else $error("external low changed the fault flag");

    AST_RESUME: assert property ($rose(boost_en_o) |-> $past(!ext_low && !s_r.latched))
        else $error("resumed while external low or fault pending");

    AST_LATCH_HOLDS: assert property (s_r.latched && !clear_all |=> s_r.latched)
        else $error("latched fault lost without clear");

    AST_CAND_NEEDS_REG: assert property (cand[0] |-> hi_s[0] && (|(lo_s[NS-1:1] & str_en[NS-1:1])))
        else $error("candidate without another string in regulation");

    AST_ISOLATE_ONE: assert property ((|str_hit) && !s_r.mode |=> (sink_en_o & $past(str_hit)) == '0)
        else $error("tripped string still sinking");

    AST_HOLD_CLEAR: assert property (s_r.hold_clr |-> s_r.hold_cnt == HOLD_CW'(HOLD_CYC)
                                     && $past(hold_cond, 2))
        else $error("hold clear without full hold time");

    AST_INPUT_UNDERVOLTAGE_LOCKOUT_OFF: assert property (input_undervoltage_lockout_s && !trip_all |=> !boost_en_o && !disconnect_en_o
                                   && sink_en_o == '0 && !s_r.latched)
        else $error("undervoltage lockout did not shut down and clear");

    COV_EXT_LOW: cover property (ext_low ##1 !ext_low);
    COV_HOLD_CLEAR: cover property (s_r.latched && s_r.hold_clr);
    COV_APB_WRITE: cover property (apb_wr && paddr_i == `LFM_CTRL_OFF);
endmodule
`default_nettype wire

// ==== hw/lfm_params.svh ====
// timing, offsets and field positions of the led string fault manager
`ifndef LFM_PARAMS_SVH
`define LFM_PARAMS_SVH

`define LFM_CLK_PERIOD_NS  10
`define LFM_DET_TIME_NS    2000
`define LFM_DET_CYC        ((`LFM_DET_TIME_NS + `LFM_CLK_PERIOD_NS - 1) / `LFM_CLK_PERIOD_NS)
`define LFM_DET_CW         8
`define LFM_HOLD_TIME_MS   16
`define LFM_HOLD_CYC       ((`LFM_HOLD_TIME_MS * 1000000) / `LFM_CLK_PERIOD_NS)
`define LFM_HOLD_CW        21
`define LFM_NSTR           4
`define LFM_DRV_HIST       4

`define LFM_AW             12
`define LFM_CTRL_OFF       12'h000
`define LFM_STAT_OFF       12'h004

`define LFM_CTRL_MODE_BIT  0
`define LFM_CTRL_MASK_LSB  4
`define LFM_MODE_RST       1'b0
`define LFM_MASK_RST       4'hf

`define LFM_STAT_FLAG_LSB  0
`define LFM_STAT_DIS_LSB   4
`define LFM_STAT_LAT_BIT   8
`define LFM_STAT_EXT_BIT   9
`define LFM_STAT_DRV_BIT   10

`endif

// ==== hw/lfm_pkg.sv ====
// state types of the led string fault manager
`include "lfm_params.svh"
package lfm_pkg;
    typedef enum logic [1:0] {STR_RUN, STR_OFF, STR_TRY, STR_PASS} lfm_str_st_t;

    typedef struct packed {
        lfm_str_st_t             st;
        logic                    flag;
        logic                    hit;
        logic [`LFM_DET_CW-1:0]  cnt;
    } lfm_str_reg_t;

    typedef struct packed {
        logic                     mode;
        logic [`LFM_NSTR-1:0]     str_mask;
        logic                     dim_d;
        logic                     latched;
        logic [`LFM_DRV_HIST-1:0] drv_hist;
        logic [`LFM_HOLD_CW-1:0]  hold_cnt;
        logic                     hold_clr;
        logic                     boost;
        logic                     disc;
        logic [`LFM_NSTR-1:0]     sinks;
        logic                     oe_n;
        logic                     al_lvl;
        logic                     pready;
        logic                     pslverr;
        logic [31:0]              prdata;
    } lfm_top_reg_t;
endpackage

// ==== hw/lfm_str_if.sv ====
// link between the manager and one string checker
`timescale 1ns/1ns
`default_nettype none
interface lfm_str_if;
    logic dim;
    logic dim_rise;
    logic cand;
    logic clear;
    logic en;
    logic flag;
    logic hit;
    modport mgr (output dim, dim_rise, cand, clear, input en, flag, hit);
    modport str (input dim, dim_rise, cand, clear, output en, flag, hit);
endinterface
`default_nettype wire

// ==== hw/lfm_string.sv ====
// partial-short checker and retry sequence for one led string
`timescale 1ns/1ns
`default_nettype none
`include "lfm_params.svh"
module lfm_string (
    input  wire logic clk_i,
    input  wire logic reset_i,
    lfm_str_if.str    sif
);
    localparam int DET = `LFM_DET_CYC;
    localparam int CW  = `LFM_DET_CW;

    lfm_pkg::lfm_str_reg_t s_r;
    lfm_pkg::lfm_str_reg_t s_nxt;
    logic                  det;

    always_comb begin
        s_nxt     = s_r;
        s_nxt.hit = 1'b0;
        s_nxt.cnt = (sif.dim && sif.cand) ? s_r.cnt + 1'b1 : '0;
        det       = sif.dim && sif.cand && (s_r.cnt == CW'(DET - 1));
        case (s_r.st)
            lfm_pkg::STR_OFF: begin
                s_nxt.cnt = '0;
                if (sif.dim_rise) begin
                    s_nxt.st = lfm_pkg::STR_TRY;
                end
            end
            lfm_pkg::STR_TRY: begin
                if (!sif.dim) begin
                    s_nxt.st = lfm_pkg::STR_PASS;
                end
            end
            lfm_pkg::STR_PASS: begin
                if (sif.dim_rise) begin
                    s_nxt.st   = lfm_pkg::STR_RUN;
                    s_nxt.flag = 1'b0;
                end
            end
            default: begin
            end
        endcase
        if (sif.clear) begin
            s_nxt = '0;
        end
        // a trip in the same cycle as a clear wins
        if (det && s_r.st != lfm_pkg::STR_OFF) begin
            s_nxt.st   = lfm_pkg::STR_OFF;
            s_nxt.flag = 1'b1;
            s_nxt.hit  = 1'b1;
            s_nxt.cnt  = '0;
        end
    end

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign sif.en   = (s_r.st != lfm_pkg::STR_OFF);
    assign sif.flag = s_r.flag;
    assign sif.hit  = s_r.hit;

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (reset_i);

    AST_DIM_LOW_IGNORED: assert property (!sif.dim |=> !sif.hit)
        else $error("partial short acted on while dimming low");
    AST_DET_TIME: assert property (sif.hit |-> $past(sif.dim && sif.cand, DET) && !sif.en && sif.flag)
        else $error("string tripped without full detection time");
    AST_RETRY: assert property (s_r.st == lfm_pkg::STR_OFF && sif.dim_rise && !sif.clear |=> sif.en && sif.flag)
        else $error("disabled string not retried at dimming rise");
    AST_PASS_KEEPS_FLAG: assert property (s_r.st == lfm_pkg::STR_TRY && !sif.dim && !sif.clear
                                          |=> sif.en && sif.flag)
        else $error("flag dropped in first passing period");
    AST_RELEASE: assert property ($fell(sif.flag) |-> $past(sif.clear || (s_r.st == lfm_pkg::STR_PASS && sif.dim_rise)))
        else $error("flag released at wrong moment");
    COV_TRIP: cover property (sif.hit);
    COV_RELEASE: cover property (s_r.st == lfm_pkg::STR_PASS && sif.dim_rise);
endmodule
`default_nettype wire

// ==== hw/lfm_sync.sv ====
// two-flop synchroniser for the fault manager inputs
`timescale 1ns/1ns
`default_nettype none
module lfm_sync #(
    parameter int W = 1
) (
    input  wire logic         clk_i,
    input  wire logic         reset_i,
    input  wire logic [W-1:0] d_i,
    output logic      [W-1:0] q_o
);
    typedef struct packed {
        logic [W-1:0] meta;
        logic [W-1:0] stab;
    } lfm_sync_reg_t;

    lfm_sync_reg_t s_r;
    lfm_sync_reg_t s_nxt;

    always_comb begin
        s_nxt      = s_r;
        s_nxt.meta = d_i;
        s_nxt.stab = s_r.meta;
    end

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign q_o = s_r.stab;
endmodule
`default_nettype wire

// ==== tb/lfm_alarm_peer.sv ====
// open-drain alarm wire with pull-up, shared with a peer that may pull or force it
`timescale 1ns/1ns
`default_nettype none
module lfm_alarm_peer (
    input  wire logic dut_oe_n_i,
    input  wire logic dut_lvl_i,
    input  wire logic pull_low_i,
    input  wire logic force_high_i,
    output logic      line_o
);
    // a forced-high wire overrides every pull, so latches can be shown to survive it
    always_comb begin
        if (force_high_i) begin
            line_o = 1'b1;
        end else begin
            line_o = ~(pull_low_i | (~dut_oe_n_i & ~dut_lvl_i));
        end
    end
endmodule
`default_nettype wire

// ==== tb/lfm_fault_mgr_tb.sv ====
// self-checking bench of the led string fault manager
`timescale 1ns/1ns
`default_nettype none
`include "lfm_params.svh"
`define CHK(g, e, m) begin n_tests++; if ((g) !== (e)) begin errors++; $display("MISMATCH %0t %s", $time, m); end end
module lfm_fault_mgr_tb;
    localparam int HOLD = 64;
    typedef struct packed {
        logic        wr;
        logic [11:0] a;
        logic [31:0] wd;
        logic [31:0] exp;
        logic        err;
    } lfm_row_t;
    logic        clk, rst, psel, pen, pwr, pready, pslverr, er;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd, st;
    logic        enable, dim, input_undervoltage_lockout, latch_f, line, al_o, oe_n, boost, disc, pull, fhigh;
    logic [3:0]  over, inreg, sinks;
    int          errors, n_tests;
    lfm_row_t    rows [6] = '{
        '{1'b0, 12'h000, 32'h0, 32'h000000f0, 1'b0},
        '{1'b1, 12'h004, 32'hffffffff, 32'h0, 1'b0},
        '{1'b0, 12'h004, 32'h0, 32'h00000000, 1'b0},
        '{1'b1, 12'h008, 32'h00000001, 32'h0, 1'b1},
        '{1'b0, 12'h008, 32'h0, 32'h00000000, 1'b1},
        '{1'b1, 12'h000, 32'h000000f0, 32'h0, 1'b0}
    };

    lfm_fault_mgr #(.HOLD_CYC(HOLD)) dut (
        .clk_i(clk), .reset_i(rst), .psel_i(psel), .penable_i(pen), .pwrite_i(pwr),
        .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready),
        .pslverr_o(pslverr), .enable_i(enable), .dim_i(dim), .input_undervoltage_lockout_i(input_undervoltage_lockout),
        .latch_fault_i(latch_f), .over_partial_short_threshold_i(over), .pin_in_regulation_i(inreg),
        .alarm_i(line), .alarm_o(al_o), .alarm_oe_n_o(oe_n), .boost_en_o(boost),
        .disconnect_en_o(disc), .sink_en_o(sinks)
    );
    lfm_alarm_peer peer (
        .dut_oe_n_i(oe_n), .dut_lvl_i(al_o), .pull_low_i(pull), .force_high_i(fhigh), .line_o(line)
    );

    always #5 clk = ~clk;

    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
    endtask

    task automatic done(input string s);
        $display("test %s done", s);
    endtask

    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] wd,
                       output logic [31:0] r, output logic e);
        int k;
        @(posedge clk);
        psel   <= 1'b1;
        pen    <= 1'b0;
        pwr    <= w;
        paddr  <= a;
        pwdata <= wd;
        @(posedge clk);
        pen <= 1'b1;
        k = 0;
        do begin
            @(posedge clk);
            k++;
        end while (pready !== 1'b1 && k < 20);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        pen  <= 1'b0;
        if (k >= 20) `CHK(1'b0, 1'b1, "apb no ready");
    endtask

    task automatic rs();
        apb(1'b0, `LFM_STAT_OFF, 32'h0, st, er);
    endtask

    task automatic results();
        $display("checks %0d mismatches %0d", n_tests, errors);
        if (errors == 0 && n_tests > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    initial begin
        #200000;
        errors++;
        $display("MISMATCH %0t watchdog expired", $time);
        results();
    end

    initial begin
        clk = 1'b0;
        errors = 0;
        n_tests = 0;
        {rst, psel, pen, pwr, enable, dim, input_undervoltage_lockout, latch_f, pull, fhigh} <= 10'h200;
        {paddr, pwdata, over, inreg} <= '0;
        cyc(8);
        `CHK({boost, disc, sinks, oe_n, pready, prdata}, 40'h02_0000_0000, "reset outputs");
        rst <= 1'b0;
        foreach (rows[i]) begin
            apb(rows[i].wr, rows[i].a, rows[i].wd, rd, er);
            `CHK(er, rows[i].err, "apb error response");
            if (!rows[i].wr) `CHK(rd, rows[i].exp, "apb read data");
        end
        done("registers");
        enable <= 1'b1;
        dim    <= 1'b1;
        cyc(8);
        `CHK({boost, disc, sinks, oe_n, al_o}, 8'hfe, "normal run");
        pull <= 1'b1;
        cyc(8);
        `CHK({boost, disc, sinks, oe_n}, 7'h7f, "isolate line ignored");
        pull <= 1'b0;
        over <= 4'b0100;
        cyc(250);
        `CHK(oe_n, 1'b1, "no trip without regulated peer");
        dim   <= 1'b0;
        over  <= 4'b0010;
        inreg <= 4'b0001;
        cyc(300);
        `CHK(oe_n, 1'b1, "no trip while dim low");
        dim <= 1'b1;
        cyc(150);
        `CHK({sinks, oe_n}, 5'b1111_1, "trip before detection time");
        cyc(65);
        `CHK({sinks, oe_n}, 5'b1101_0, "string isolated");
        rs();
        `CHK(st[7:0], 8'h22, "trip status");
        done("partial short");
        dim <= 1'b0;
        cyc(20);
        dim <= 1'b1;
        cyc(230);
        `CHK({sinks, oe_n}, 5'b1101_0, "retry trips again");
        rs();
        `CHK(st[7:0], 8'h22, "retry status");
        over <= 4'b0000;
        dim  <= 1'b0;
        cyc(20);
        dim <= 1'b1;
        cyc(230);
        `CHK({sinks, oe_n}, 5'b1111_0, "retry passes");
        rs();
        `CHK(st[7:0], 8'h02, "flag kept on pass");
        dim <= 1'b0;
        cyc(20);
        dim <= 1'b1;
        cyc(10);
        `CHK(oe_n, 1'b1, "alarm released");
        rs();
        `CHK(st[7:0], 8'h00, "flag cleared");
        done("retry");
        apb(1'b1, `LFM_CTRL_OFF, 32'h000000f1, rd, er);
        cyc(8);
        pull <= 1'b1;
        cyc(8);
        `CHK({boost, disc, sinks}, 6'b01_0000, "external low shutdown");
        rs();
        `CHK({st[10:8], st[3:0]}, 7'b010_0000, "flags unchanged");
        pull <= 1'b0;
        cyc(8);
        `CHK({boost, disc, sinks}, 6'h3f, "resume");
        latch_f <= 1'b1;
        cyc(5);
        latch_f <= 1'b0;
        pull    <= 1'b1;
        cyc(8);
        pull <= 1'b0;
        cyc(8);
        `CHK(boost, 1'b0, "no resume with latch pending");
        input_undervoltage_lockout <= 1'b1;
        cyc(8);
        `CHK({boost, disc, sinks}, 6'h00, "lockout shutdown");
        input_undervoltage_lockout <= 1'b0;
        cyc(8);
        rs();
        `CHK({st[8], boost}, 2'b01, "lockout clears latch");
        done("shutdown all");
        over <= 4'b0010;
        cyc(215);
        `CHK({boost, disc, sinks, oe_n, line}, 8'h00, "latched trip");
        fhigh <= 1'b1;
        cyc(10);
        rs();
        `CHK({st[10], st[8], boost}, 3'b110, "forced high keeps latch");
        fhigh  <= 1'b0;
        over   <= 4'b0000;
        enable <= 1'b0;
        cyc(HOLD - 10);
        enable <= 1'b1;
        cyc(4);
        rs();
        `CHK(st[8], 1'b1, "short low keeps latch");
        enable <= 1'b0;
        cyc(HOLD + 10);
        rs();
        `CHK(st[8], 1'b0, "hold low clears latch");
        enable <= 1'b1;
        cyc(8);
        `CHK({boost, disc, sinks, oe_n}, 7'h7f, "restart after clear");
        done("latch clear");
        rst <= 1'b1;
        cyc(4);
        `CHK({boost, disc, sinks, oe_n}, 7'h01, "mid-run reset outputs");
        rst <= 1'b0;
        cyc(8);
        apb(1'b0, `LFM_CTRL_OFF, 32'h0, rd, er);
        `CHK(rd, 32'h000000f0, "control back to reset value");
        `CHK({boost, disc, sinks, oe_n}, 7'h7f, "run after mid-run reset");
        done("reset");
        results();
    end
endmodule
`default_nettype wire
